// File: hw/shift_latch_map.svh
// timing and width constants for the serial shift-latch driver link
`ifndef SHIFT_LATCH_MAP_SVH
`define SHIFT_LATCH_MAP_SVH
`define WORD_BITS 20
`define SHIFT_RESET 20'h0_0000
`define LATCH_RESET 20'h0_0000
`define SCLK_MIN_PERIOD_NS 200
`define CLK_PERIOD_NS 25
`define HALF_CYCLES (((`SCLK_MIN_PERIOD_NS / 2) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: hw/shift_latch_pkg.sv
// types shared by both ends of the serial shift-latch link
package shift_latch_pkg;
  typedef logic [19:0] word_type;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_low = 2'b01,
    st_high = 2'b10,
    st_load = 2'b11
  } host_state_type;
endpackage

// File: hw/shift_latch_if.sv
// interface joining controller and driver
`timescale 1ns/1ps
`default_nettype none
interface shift_latch_if;
  logic sclk;
  logic sdata;
  logic load;
  logic blank;
  logic sout;
  modport device (input sclk, input sdata, input load, input blank, output sout);
  modport host (output sclk, output sdata, output load, output blank, input sout);
endinterface // shift_latch_if
`default_nettype wire

// File: hw/shift_latch_driver.sv
// device end: 20-bit shift register, transparent latch, blanked outputs
// Operation
// R1 - 20-bit shift register, one step per rise
// R2 - data into bit zero, others move up
// R3 - controller keeps data stable around rise
// R4 - word is 20 bits, zero to nineteen
// R5 - latch transparent while load high
// R6 - falling load captures, low holds
// R7 - serial out is last stage
// R8 - blank high forces outputs low
// R9 - blank low outputs follow latch
// R10 - shifting and latching ignore blank
// R11 - reset clears everything, outputs low
// R12 - controller shifts msb first, then loads
// R13 - load high shows shifting live
// R14 - every rise shifts, latest bits latched
// R15 - each device gets own load
// R16 - latch bit k drives output k
`timescale 1ns/1ps
`default_nettype none
`include "shift_latch_map.svh"

module shift_latch_driver
  import shift_latch_pkg::*;
#(
  // R4 word is 20 bits
  parameter int WIDTH = `WORD_BITS
) (
  input wire logic clk,
  input wire logic rst,
  shift_latch_if.device link,
  output logic [WIDTH-1:0] driver_outputs
);
  import shift_latch_pkg::*;

  localparam logic [WIDTH-1:0] SHIFT_INIT = WIDTH'(`SHIFT_RESET);
  localparam logic [WIDTH-1:0] LATCH_INIT = WIDTH'(`LATCH_RESET);

  // every register of this end lives here
  typedef struct packed {
    // clock level seen on the previous edge
    logic sclk_d;
    // serial shift register, bit zero takes the data
    logic [WIDTH-1:0] shift;
    // output latch
    logic [WIDTH-1:0] latch;
    // gated outputs, registered so pins come from flops
    logic [WIDTH-1:0] outs;
    // last stage towards the next device
    logic sout;
  } dev_state_type;

  dev_state_type s_r;
  dev_state_type s_nxt;

  logic rise;
  logic latch_open;
  logic blank_on;
  logic [WIDTH-1:0] shift_step;
  logic [WIDTH-1:0] shift_next;
  logic [WIDTH-1:0] latch_next;
  logic [WIDTH-1:0] outs_next;

  // inputs are synchronous, so the sampled clock edge is exact
  always_comb begin
    s_nxt = s_r;
    rise = 1'b0;
    latch_open = link.load;
    blank_on = link.blank;
    shift_step = '0;
    shift_next = s_r.shift;
    latch_next = s_r.latch;
    outs_next = '0;

    // one clock of delay costs nothing at these link speeds
    s_nxt.sclk_d = link.sclk;
    rise = link.sclk & ~s_r.sclk_d;

    // R2 data into bit zero
    shift_step[0] = link.sdata;
    for (int k = 1; k < WIDTH; k++) begin
      shift_step[k] = s_r.shift[k-1];
    end

    // R1 shift on rise
    // R14 every rise shifts
    if (rise) begin
      shift_next = shift_step;
    end
    s_nxt.shift = shift_next;

    // R5 transparent while high
    // R13 live outputs while loading
    // R10 independent of blank
    if (latch_open) begin
      latch_next = shift_next;
    end

    // R6 hold while low
    s_nxt.latch = latch_next;

    // R7 last stage out
    s_nxt.sout = shift_next[WIDTH-1];

    // R8 blank forces low
    // R9 follow latch
    // R16 bit k to output k
    for (int k = 0; k < WIDTH; k++) begin
      outs_next[k] = latch_next[k] & ~blank_on;
    end
    s_nxt.outs = outs_next;
  end

  // R11 clear at reset
  // clock history starts low like an idle link, so no false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.sclk_d <= 1'b0;
      s_r.shift <= SHIFT_INIT;
      s_r.latch <= LATCH_INIT;
      s_r.outs <= '0;
      s_r.sout <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign driver_outputs = s_r.outs;
  assign link.sout = s_r.sout;
endmodule // shift_latch_driver
`default_nettype wire

// File: hw/shift_latch_host.sv
// controller end: shifts a word msb first then pulses load
`timescale 1ns/1ps
`default_nettype none
`include "shift_latch_map.svh"

module shift_latch_host
  import shift_latch_pkg::*;
#(
  parameter int WIDTH = `WORD_BITS
) (
  input wire logic clk,
  input wire logic rst,
  shift_latch_if.host link,
  input wire logic start,
  input wire shift_latch_pkg::word_type word,
  input wire logic blank_req,
  output logic busy
);
  import shift_latch_pkg::*;

  typedef struct packed {
    host_state_type st;
    logic [WIDTH-1:0] data;
    logic [4:0] bits;
    logic [3:0] cnt;
    logic sclk;
    logic sdata;
    logic load;
    logic blank;
    logic busy;
  } host_reg_type;

  host_reg_type h_r;
  host_reg_type h_nxt;
  localparam logic [3:0] HALF = 4'(`HALF_CYCLES);

  always_comb begin
    h_nxt = h_r;
    h_nxt.blank = blank_req;
    h_nxt.cnt = (h_r.cnt == 4'h0) ? 4'h0 : h_r.cnt - 4'h1;
    unique case (h_r.st)
      st_idle: begin
        h_nxt.load = 1'b0;
        // R12 clock low first
        h_nxt.sclk = 1'b0;
        h_nxt.busy = 1'b0;
        if (start) begin
          h_nxt.data = word;
          h_nxt.bits = 5'(WIDTH);
          h_nxt.busy = 1'b1;
          h_nxt.sdata = word[WIDTH-1];
          h_nxt.cnt = HALF;
          h_nxt.st = st_low;
        end
      end
      st_low: begin
        // R3 data set half a period before rise
        if (h_r.cnt == 4'h0) begin
          h_nxt.sclk = 1'b1;
          h_nxt.cnt = HALF;
          h_nxt.st = st_high;
        end
      end
      st_high: begin
        if (h_r.cnt == 4'h0) begin
          h_nxt.sclk = 1'b0;
          h_nxt.cnt = HALF;
          // R12 msb first, bit zero last
          h_nxt.data = {h_r.data[WIDTH-2:0], 1'b0};
          h_nxt.sdata = h_r.data[WIDTH-2];
          h_nxt.bits = h_r.bits - 5'h1;
          h_nxt.st = (h_r.bits == 5'h1) ? st_load : st_low;
        end
      end
      st_load: begin
        // R15 own load strobe
        h_nxt.load = 1'b1;
        if (h_r.cnt == 4'h0) begin
          h_nxt.load = 1'b0;
          h_nxt.st = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign link.sclk = h_r.sclk;
  assign link.sdata = h_r.sdata;
  assign link.load = h_r.load;
  assign link.blank = h_r.blank;
  assign busy = h_r.busy;
endmodule // shift_latch_host
`default_nettype wire

// File: dv/shift_latch_checker.sv
// link checker for the shift-latch pair
`timescale 1ns/1ps
`default_nettype none
module shift_latch_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load,
  input wire logic blank,
  input wire logic sout,
  input wire logic [19:0] driver_outputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst; disable iff (1'b0) rst && $past(rst) |-> driver_outputs == 0 && !sout;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_blank; blank && $past(blank) |-> driver_outputs == 0; endproperty
  a_blank: assert property (p_blank) else $error("blank");
  // stable only once blank and load settle
  property p_hold; !load && !$past(load) && !$past(load, 2) && !blank && !$past(blank)
    && !$past(blank, 2) |-> $stable(driver_outputs); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_sout; $changed(sout) |-> sclk && !$past(sclk, 3); endproperty
  a_sout: assert property (p_sout) else $error("sout");
  property p_tail; load && $past(load) && $past(load, 2) && !blank && !$past(blank)
    && !$past(blank, 2) |-> driver_outputs[19] == sout; endproperty
  a_tail: assert property (p_tail) else $error("tail");
  property p_din; $rose(sclk) |-> $stable(sdata); endproperty
  a_din: assert property (p_din) else $error("din");
  property p_high; $rose(sclk) |=> sclk [*4] ##1 !sclk; endproperty
  a_high: assert property (p_high) else $error("high");
  property p_load; $rose(load) |-> !sclk; endproperty
  a_load: assert property (p_load) else $error("load");
endmodule // shift_latch_checker
`default_nettype wire

// File: dv/tb_top.sv
// bench: host end drives device end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import shift_latch_pkg::*;
  logic clk = 0, rst = 1, start = 0, blank_req = 0, busy;
  word_type word = 20'h0_0000, outs;
  int failures = 0, samples_checked = 0;
  shift_latch_if link();
  shift_latch_host shift_latch_host_inst(.clk(clk), .rst(rst), .link(link), .start(start),
    .word(word), .blank_req(blank_req), .busy(busy));
  shift_latch_driver shift_latch_driver_inst(.clk(clk), .rst(rst), .link(link),
    .driver_outputs(outs));
  shift_latch_checker shift_latch_checker_inst(.clk(clk), .rst(rst), .sclk(link.sclk),
    .sdata(link.sdata), .load(link.load), .blank(link.blank), .sout(link.sout),
    .driver_outputs(outs));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string nm, input word_type exp, input word_type got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // busy bounded: a hung host ends the run
  task automatic put(input word_type w);
    int n;
    @(posedge clk);
    word <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge clk);
    if (n == 2000) begin
      failures++;
      final_report();
    end
    repeat (3) @(posedge clk);
    $display("word %h done", w);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk("outs", 20'h0_0000, outs);
    chk("sout", 20'h0_0000, {19'h0_0000, link.sout});
    put(20'hA_5C3F);
    chk("outs", 20'hA_5C3F, outs);
    blank_req <= 1'b1;
    put(20'h8_1E24);
    chk("outs", 20'h0_0000, outs);
    blank_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk("outs", 20'h8_1E24, outs);
    chk("sout", 20'h0_0001, {19'h0_0000, link.sout});
    final_report();
  end
endmodule // tb_top
`default_nettype wire
